// ### mbf_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbf_map.vh"
module mbf_dev_model #(parameter logic [7:0] SEL_LIMIT = 8'hc0) (
  input wire logic       rst_n_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] rd_kind_i,
  input wire logic       use_rw_i,
  input wire logic       fetch_sel_i,
  input wire logic       latch_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       fetch_i,
  input wire logic [7:0] lo_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] dat_i,
  output logic [7:0]     lo_o,
  output logic [7:0]     hi_o,
  output logic [7:0]     dat_o,
  output logic [2:0]     en_o
);
  logic [15:0] lat_q, wr_q, rd_v;
  logic        data_act, rd_act, wr_act, sel;
  assign data_act = (rd_kind_i == `MBF_RD_ECLK) ? rd_i : !rd_i;
  assign wr_act = !wr_i && (use_rw_i ? data_act : 1'b1);
  assign rd_act = ((use_rw_i ? wr_i : 1'b1) && data_act) || (fetch_sel_i && !fetch_i);
  assign sel = lat_q[15:8] < SEL_LIMIT;
  assign rd_v = lat_q ^ 16'h3c5a;
  // Both port bytes are captured as the address seen by decode.
  always @(negedge latch_i or negedge rst_n_i) if (!rst_n_i) lat_q <= 16'h0; else lat_q <= {hi_i, lo_i};
  always @(negedge wr_act or negedge rst_n_i) begin
    if (!rst_n_i) wr_q <= 16'h0;
    else case (mode_i)
      `MBF_MODE_BURST:  wr_q <= {hi_i, lo_i};
      `MBF_MODE_MUX:    wr_q <= {8'h00, lo_i};
      `MBF_MODE_NONMUX: wr_q <= {8'h00, dat_i};
      default:          wr_q <= {8'h00, hi_i};
    endcase
  end
  assign en_o = !(rd_act && sel && rst_n_i) ? 3'b000 : (mode_i == `MBF_MODE_MUX) ? 3'b001 :
    (mode_i == `MBF_MODE_NONMUX) ? 3'b100 : (mode_i == `MBF_MODE_PAGE) ? 3'b010 : 3'b011;
  assign lo_o = rd_v[7:0];
  assign hi_o = (mode_i == `MBF_MODE_BURST) ? rd_v[15:8] : rd_v[7:0];
  assign dat_o = rd_v[7:0];
endmodule
`default_nettype wire

// ### mbf_host.v
`timescale 1ns/1ps
`default_nettype none
`include "mbf_map.vh"

// Function
// - Multiplexed host: shared low byte on lower port, high byte upper.
// - Non-multiplexed host: A0-7 lower, A8-15 upper, data on separate port.
// - Page mode: plain low address lower, data with high byte upper.
// - Burst mode: A4-11 with D0-7 lower, A12-19 with D8-15 upper.
// - First control input: active-low write strobe or read/write direction.
// - Second control input: read strobe, E clock, data strobe or program-select.
// - Over sixteen address bits with program-select as read: route it second.
// - Reset input held low while power is first applied.
module mbf_host (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire [1:0]  mode_i,
  input  wire [1:0]  rd_kind_i,
  input  wire        use_rw_i,
  input  wire        fetch_sel_i,
  input  wire        req_i,
  input  wire        req_we_i,
  input  wire        req_fetch_i,
  input  wire [19:0] req_addr_i,
  input  wire [15:0] req_wdata_i,
  output wire        req_ready_o,
  output reg  [15:0] rsp_rdata_o,
  output reg         rsp_valid_o,
  output reg         dev_reset_n_o,
  output reg         addr_latch_o,
  output reg         ctrl_input_write_o,
  output reg         ctrl_input_read_o,
  output reg         ctrl_input_fetch_o,
  output reg  [7:0]  lower_addr_data_port_o,
  output reg         lower_addr_data_port_oe_n_o,
  input  wire [7:0]  lower_addr_data_port_i,
  output reg  [7:0]  upper_addr_data_port_o,
  output reg         upper_addr_data_port_oe_n_o,
  input  wire [7:0]  upper_addr_data_port_i,
  output reg  [7:0]  data_port_o,
  output reg         data_port_oe_n_o,
  input  wire [7:0]  data_port_i
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam ST_RESET = 3'h0;
  localparam ST_IDLE  = 3'h1;
  localparam ST_ADDR  = 3'h2;
  localparam ST_STRB  = 3'h3;
  localparam ST_HOLD  = 3'h4;

  // Counter load values, sized to the counter so no bits are dropped silently.
  localparam [`MBF_CNT_W-1:0] ADDR_LD = `MBF_ADDR_CYC - 1;
  localparam [`MBF_CNT_W-1:0] STRB_LD = `MBF_STRB_CYC - 1;
  localparam [`MBF_CNT_W-1:0] HOLD_LD = `MBF_HOLD_CYC - 1;

  reg  [2:0]              state_ff;
  reg  [`MBF_CNT_W-1:0]   cnt_ff;
  reg                     we_ff;
  reg                     fetch_ff;
  reg  [19:0]             addr_ff;
  reg  [15:0]             wdata_ff;
  reg  [1:0]              mode_ff;
  reg  [1:0]              kind_ff;
  reg                     rw_ff;
  reg                     fsel_ff;
  reg                     strobe;
  reg                     rd_act;
  reg                     wr_act;
  reg  [7:0]              lo_addr;
  reg  [7:0]              hi_addr;

  assign req_ready_o = (state_ff == ST_IDLE);

  // ----------------------------------------------------------------
  // Address byte placement per wiring mode
  // ----------------------------------------------------------------
  always @* begin
    case (mode_ff)
      `MBF_MODE_BURST: begin
        lo_addr = addr_ff[11:4];
        hi_addr = addr_ff[19:12];
      end
      default: begin
        lo_addr = addr_ff[7:0];
        hi_addr = addr_ff[15:8];
      end
    endcase
  end

  always @* begin
    strobe = (state_ff == ST_STRB);
    rd_act = strobe && !we_ff;
    wr_act = strobe && we_ff;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff      <= ST_RESET;
      cnt_ff        <= `MBF_RESET_CYC;
      dev_reset_n_o <= 1'b0;
      we_ff         <= 1'b0;
      fetch_ff      <= 1'b0;
      addr_ff       <= 20'h00000;
      wdata_ff      <= 16'h0000;
      mode_ff       <= `MBF_MODE_MUX;
      kind_ff       <= `MBF_RD_STROBE;
      rw_ff         <= 1'b0;
      fsel_ff       <= 1'b0;
      rsp_valid_o   <= 1'b0;
      rsp_rdata_o   <= 16'h0000;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state_ff)
        ST_RESET: begin
          if (cnt_ff == 8'h00) begin
            dev_reset_n_o <= 1'b1;
            state_ff      <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ST_IDLE: begin
          if (req_i) begin
            we_ff    <= req_we_i;
            fetch_ff <= req_fetch_i && !req_we_i;
            addr_ff  <= req_addr_i;
            wdata_ff <= req_wdata_i;
            mode_ff  <= mode_i;
            kind_ff  <= rd_kind_i;
            rw_ff    <= use_rw_i;
            fsel_ff  <= fetch_sel_i;
            cnt_ff   <= ADDR_LD;
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cnt_ff == 8'h00) begin
            cnt_ff   <= STRB_LD;
            state_ff <= ST_STRB;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ST_STRB: begin
          if (cnt_ff == 8'h00) begin
            if (!we_ff) begin
              rsp_valid_o <= 1'b1;
              if (mode_ff == `MBF_MODE_NONMUX) begin
                rsp_rdata_o <= {8'h00, data_port_i};
              end else if (mode_ff == `MBF_MODE_PAGE) begin
                rsp_rdata_o <= {8'h00, upper_addr_data_port_i};
              end else if (mode_ff == `MBF_MODE_BURST) begin
                rsp_rdata_o <= {upper_addr_data_port_i, lower_addr_data_port_i};
              end else begin
                rsp_rdata_o <= {8'h00, lower_addr_data_port_i};
              end
            end
            cnt_ff   <= HOLD_LD;
            state_ff <= ST_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ST_HOLD: begin
          if (cnt_ff == 8'h00) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, registered
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      addr_latch_o                <= 1'b0;
      ctrl_input_write_o          <= 1'b1;
      ctrl_input_read_o           <= 1'b1;
      ctrl_input_fetch_o          <= 1'b1;
      lower_addr_data_port_o      <= 8'h00;
      lower_addr_data_port_oe_n_o <= 1'b1;
      upper_addr_data_port_o      <= 8'h00;
      upper_addr_data_port_oe_n_o <= 1'b1;
      data_port_o                 <= 8'h00;
      data_port_oe_n_o            <= 1'b1;
    end else begin
      // The latch strobe rises with the address phase and falls before the strobe.
      addr_latch_o <= (state_ff == ST_IDLE) && req_i;
      // Lower port: address, then data when it is shared with the low byte.
      if (state_ff == ST_IDLE && req_i) begin
        lower_addr_data_port_oe_n_o <= 1'b0;
        upper_addr_data_port_oe_n_o <= 1'b0;
        lower_addr_data_port_o      <= (mode_i == `MBF_MODE_BURST) ? req_addr_i[11:4] : req_addr_i[7:0];
        upper_addr_data_port_o      <= (mode_i == `MBF_MODE_BURST) ? req_addr_i[19:12] : req_addr_i[15:8];
      end else if (state_ff == ST_ADDR && cnt_ff == 8'h00) begin
        case (mode_ff)
          `MBF_MODE_MUX: begin
            lower_addr_data_port_oe_n_o <= !we_ff;
            lower_addr_data_port_o      <= wdata_ff[7:0];
            upper_addr_data_port_o      <= hi_addr;
          end
          `MBF_MODE_PAGE: begin
            upper_addr_data_port_oe_n_o <= !we_ff;
            upper_addr_data_port_o      <= wdata_ff[7:0];
            lower_addr_data_port_o      <= lo_addr;
          end
          `MBF_MODE_BURST: begin
            lower_addr_data_port_oe_n_o <= !we_ff;
            upper_addr_data_port_oe_n_o <= !we_ff;
            lower_addr_data_port_o      <= wdata_ff[7:0];
            upper_addr_data_port_o      <= wdata_ff[15:8];
          end
          default: begin
            data_port_oe_n_o <= !we_ff;
            data_port_o      <= wdata_ff[7:0];
          end
        endcase
      end else if (state_ff == ST_HOLD && cnt_ff == 8'h00) begin
        lower_addr_data_port_oe_n_o <= 1'b1;
        upper_addr_data_port_oe_n_o <= 1'b1;
        data_port_oe_n_o            <= 1'b1;
      end
      // First control input: write strobe or read/write direction.
      if (rw_ff) begin
        ctrl_input_write_o <= (state_ff == ST_IDLE) ? 1'b1 : !we_ff;
      end else begin
        ctrl_input_write_o <= !(state_ff == ST_ADDR && cnt_ff == 8'h00 ? we_ff : wr_act && cnt_ff != 8'h00);
      end
      // Second control input: read-type signal per configured kind.
      case (kind_ff)
        `MBF_RD_ECLK:    ctrl_input_read_o <= (state_ff == ST_ADDR && cnt_ff == 8'h00) || (strobe && cnt_ff != 8'h00);
        `MBF_RD_DSTROBE: ctrl_input_read_o <= !((state_ff == ST_ADDR && cnt_ff == 8'h00) || (strobe && cnt_ff != 8'h00));
        `MBF_RD_PSEL:    ctrl_input_read_o <= !((state_ff == ST_ADDR && cnt_ff == 8'h00 && !we_ff) || (rd_act && cnt_ff != 8'h00));
        default:         ctrl_input_read_o <= !((state_ff == ST_ADDR && cnt_ff == 8'h00 && !we_ff) || (rd_act && cnt_ff != 8'h00));
      endcase
      // Third control input: code-fetch select, or a generic level.
      if (fsel_ff) begin
        ctrl_input_fetch_o <= !((state_ff == ST_ADDR && cnt_ff == 8'h00 && fetch_ff) || (rd_act && fetch_ff && cnt_ff != 8'h00));
      end else begin
        ctrl_input_fetch_o <= fetch_sel_i;
      end
    end
  end

endmodule
`default_nettype wire

// ### mbf_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbf_map.vh"
module mbf_chk (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [1:0]  mode_i,
  input wire logic [1:0]  rd_kind_i,
  input wire logic        use_rw_i,
  input wire logic        fetch_sel_i,
  input wire logic        req_i,
  input wire logic        req_we_i,
  input wire logic        req_fetch_i,
  input wire logic [19:0] req_addr_i,
  input wire logic        req_ready_o,
  input wire logic        dev_reset_n_o,
  input wire logic        addr_latch_o,
  input wire logic        ctrl_input_write_o,
  input wire logic        ctrl_input_read_o,
  input wire logic        ctrl_input_fetch_o,
  input wire logic [7:0]  lower_addr_data_port_o,
  input wire logic        lower_addr_data_port_oe_n_o,
  input wire logic [7:0]  upper_addr_data_port_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take; req_i && req_ready_o; endsequence
  sequence s_low4(sig); !sig [*4] ##1 sig; endsequence
  a_rst_hold: assert property (disable iff (1'b0) !rst_n_i |=> !dev_reset_n_o)
    else $error("device reset released during reset");
  a_rst_stretch: assert property ($rose(rst_n_i) |-> !dev_reset_n_o [*8])
    else $error("device reset released too early");
  a_latch_pulse: assert property (s_take |=> addr_latch_o ##1 !addr_latch_o)
    else $error("address latch pulse wrong");
  a_addr_ports: assert property (s_take and (mode_i != `MBF_MODE_BURST) |=> !lower_addr_data_port_oe_n_o
    && {upper_addr_data_port_o, lower_addr_data_port_o} == $past(req_addr_i[15:0]))
    else $error("address bytes wrong on ports");
  a_burst_addr: assert property (s_take and (mode_i == `MBF_MODE_BURST) |=>
    {upper_addr_data_port_o, lower_addr_data_port_o} == $past(req_addr_i[19:4]))
    else $error("burst address bytes wrong on ports");
  a_wr_strobe: assert property (s_take and (req_we_i && !use_rw_i) |-> ##3 s_low4(ctrl_input_write_o))
    else $error("write strobe shape wrong");
  a_rw_level: assert property (s_take and (!req_we_i && use_rw_i) |-> ##3 ctrl_input_write_o [*4])
    else $error("direction level not read");
  a_rd_strobe: assert property (s_take and (!req_we_i && !req_fetch_i && rd_kind_i != `MBF_RD_ECLK)
    |-> ##3 s_low4(ctrl_input_read_o)) else $error("read strobe shape wrong");
  a_fetch_idle: assert property (s_take and (!fetch_sel_i) |-> ##3 !ctrl_input_fetch_o [*4])
    else $error("generic fetch input not following level");
  a_rd_release: assert property (s_take and (!req_we_i && mode_i == `MBF_MODE_MUX)
    |-> ##3 lower_addr_data_port_oe_n_o [*4]) else $error("lower port driven during read");
endmodule
bind mbf_host mbf_chk u_chk (.mclk_i, .rst_n_i, .mode_i, .rd_kind_i, .use_rw_i, .fetch_sel_i, .req_i, .req_we_i,
  .req_fetch_i, .req_addr_i, .req_ready_o, .dev_reset_n_o, .addr_latch_o, .ctrl_input_write_o, .ctrl_input_read_o,
  .ctrl_input_fetch_o, .lower_addr_data_port_o, .lower_addr_data_port_oe_n_o, .upper_addr_data_port_o);
`default_nettype wire

// ### mbf_map.vh
`ifndef MBF_MAP_VH
`define MBF_MAP_VH
// ----------------------------------------------------------------
// Host wiring modes
// ----------------------------------------------------------------
`define MBF_MODE_MUX      2'h0
`define MBF_MODE_NONMUX   2'h1
`define MBF_MODE_PAGE     2'h2
`define MBF_MODE_BURST    2'h3
// ----------------------------------------------------------------
// Second control input signal kinds
// ----------------------------------------------------------------
`define MBF_RD_STROBE     2'h0
`define MBF_RD_ECLK       2'h1
`define MBF_RD_DSTROBE    2'h2
`define MBF_RD_PSEL       2'h3
// ----------------------------------------------------------------
// Timing in ns and derived cycles at 200 MHz
// ----------------------------------------------------------------
`define MBF_CLK_PERIOD_NS 5
`define MBF_T_ADDR_NS     10
`define MBF_T_STRB_NS     20
`define MBF_T_HOLD_NS     10
`define MBF_ADDR_CYC      ((`MBF_T_ADDR_NS + `MBF_CLK_PERIOD_NS - 1) / `MBF_CLK_PERIOD_NS)
`define MBF_STRB_CYC      ((`MBF_T_STRB_NS + `MBF_CLK_PERIOD_NS - 1) / `MBF_CLK_PERIOD_NS)
`define MBF_HOLD_CYC      ((`MBF_T_HOLD_NS + `MBF_CLK_PERIOD_NS - 1) / `MBF_CLK_PERIOD_NS)
`define MBF_RESET_CYC     8'h10
`define MBF_CNT_W         8
`endif

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbf_map.vh"
module tb_top;
  logic mclk_i = 0, rst_n_i = 0, req_i = 0, req_we_i = 0, req_fetch_i = 0, use_rw_i = 0, fetch_sel_i = 0;
  logic [1:0] mode_i = 0, rd_kind_i = 0;
  logic [19:0] req_addr_i = 0;
  logic [15:0] req_wdata_i = 0;
  logic [7:0] jr = 0;
  wire req_ready_o, rsp_valid_o, dev_reset_n_o, addr_latch_o, ctrl_input_write_o, ctrl_input_read_o;
  wire ctrl_input_fetch_o, lower_addr_data_port_oe_n_o, upper_addr_data_port_oe_n_o, data_port_oe_n_o;
  wire [15:0] rsp_rdata_o;
  wire [7:0] lower_addr_data_port_o, upper_addr_data_port_o, data_port_o, m_lo, m_hi, m_d;
  wire [7:0] lower_addr_data_port_i, upper_addr_data_port_i, data_port_i;
  wire [2:0] m_en;
  int fails = 0, total_checks = 0;
  always #2.5 mclk_i = ~mclk_i;
  // Released lines show a pattern that moves every cycle.
  always @(posedge mclk_i) jr <= {jr[6:0], ~jr[7]};
  assign lower_addr_data_port_i = !lower_addr_data_port_oe_n_o ? lower_addr_data_port_o : m_en[0] ? m_lo : jr;
  assign upper_addr_data_port_i = !upper_addr_data_port_oe_n_o ? upper_addr_data_port_o : m_en[1] ? m_hi : ~jr;
  assign data_port_i = !data_port_oe_n_o ? data_port_o : m_en[2] ? m_d : jr;
  mbf_host dut (.mclk_i, .rst_n_i, .mode_i, .rd_kind_i, .use_rw_i, .fetch_sel_i, .req_i, .req_we_i, .req_fetch_i,
    .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_rdata_o, .rsp_valid_o, .dev_reset_n_o, .addr_latch_o,
    .ctrl_input_write_o, .ctrl_input_read_o, .ctrl_input_fetch_o, .lower_addr_data_port_o,
    .lower_addr_data_port_oe_n_o, .lower_addr_data_port_i, .upper_addr_data_port_o, .upper_addr_data_port_oe_n_o,
    .upper_addr_data_port_i, .data_port_o, .data_port_oe_n_o, .data_port_i);
  mbf_dev_model u_dev (.rst_n_i(dev_reset_n_o), .mode_i, .rd_kind_i, .use_rw_i, .fetch_sel_i, .latch_i(addr_latch_o),
    .wr_i(ctrl_input_write_o), .rd_i(ctrl_input_read_o), .fetch_i(ctrl_input_fetch_o), .lo_i(lower_addr_data_port_i),
    .hi_i(upper_addr_data_port_i), .dat_i(data_port_i), .lo_o(m_lo), .hi_o(m_hi), .dat_o(m_d), .en_o(m_en));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] fit(input logic [1:0] m, input logic [15:0] v);
    return (m == `MBF_MODE_BURST) ? v : {8'h00, v[7:0]};
  endfunction
  task automatic run(input logic [1:0] m, input logic [1:0] k, input logic rw, input logic fs, input logic we,
                     input logic fe, input logic [19:0] a, input logic [15:0] wd);
    int n;
    logic v;
    logic [15:0] e;
    e = (m == `MBF_MODE_BURST) ? a[19:4] : a[15:0];
    v = 1'b0;
    {mode_i, rd_kind_i, use_rw_i, fetch_sel_i, req_we_i, req_fetch_i, req_addr_i, req_wdata_i} =
      {m, k, rw, fs, we, fe, a, wd};
    req_i = 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    #1;
    req_i = 1'b0;
    repeat (9) begin
      @(posedge mclk_i);
      #1;
      if (rsp_valid_o === 1'b1) v = 1'b1;
    end
    chk({15'h0, v}, {15'h0, !we});
    chk(u_dev.lat_q, e);
    if (we) chk(u_dev.wr_q, fit(m, wd));
    else if (e[15:8] < 8'hc0) chk(fit(m, rsp_rdata_o), fit(m, e ^ 16'h3c5a));
    $display("access done mode %0d kind %0d we %0b addr %h", m, k, we, a);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    fails++;
    wrap_up();
  end
  initial begin
    logic [31:0] r, s;
    void'($urandom(32'hacd5));
    repeat (12) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      // A direction level only pairs with an E clock or a data strobe as the timing signal.
      run(i[3:2], i[1:0], ^i[1:0], 1'b0, 1'b1, 1'b0, 20'hbfbff, 16'hffff);
      run(i[3:2], i[1:0], ^i[1:0], 1'b0, 1'b0, 1'b0, 20'hbfbff, 16'h0);
      run(i[3:2], i[1:0], ^i[1:0], 1'b0, 1'b0, 1'b0, 20'hc0c00, 16'h0);
      run(i[3:2], i[1:0], 1'b0, 1'b1, 1'b0, 1'b1, 20'h01234, 16'h0);
    end
    @(posedge mclk_i);
    #1;
    rst_n_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    chk(u_dev.lat_q, 16'h0);
    repeat (40) begin
      r = $urandom;
      s = $urandom;
      run(r[1:0], r[3:2], r[4] & (^r[3:2]), r[5], r[6], r[5] & r[7] & ~r[6], s[19:0], r[31:16]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
